// [rtl/sdm_cfg.svh]
// Purpose: Offsets, field positions, codes and timing counts for the dropout monitor
// Assumes: Register offsets are word indices; the byte address is four times the index
// Notes:   Definitions only
`ifndef SDM_CFG_SVH
`define SDM_CFG_SVH

// Register indices
`define SDM_IDX_DETECTOR_CONTROL_A       8'h00
`define SDM_IDX_THRESH      8'h01
`define SDM_IDX_WLEVEL      8'h08
`define SDM_IDX_WINTC       8'h09
`define SDM_IDX_WFLAG       8'h0A
`define SDM_IDX_WSTATE      8'h0B

// Field positions
`define SDM_SAMP_BIT        4
`define SDM_ACT_LSB         2
`define SDM_SLP_LSB         0
`define SDM_IE_BIT          0
`define SDM_EDGE_LSB        1
`define SDM_FLAG_BIT        0
`define SDM_STATE_BIT       0

// Mode, edge and margin codes
`define SDM_MODE_DIS        2'h0
`define SDM_MODE_CONT       2'h1
`define SDM_MODE_SAMP       2'h2
`define SDM_MODE_WAKE       2'h3
`define SDM_EDGE_FALL       2'h0
`define SDM_EDGE_RISE       2'h1
`define SDM_EDGE_BOTH       2'h2
`define SDM_MARGIN_OFF      2'h0

// Reset values of software registers
`define SDM_RST_WLEVEL      2'h0
`define SDM_RST_WEDGE       2'h0

// Timing
`define SDM_CLK_HZ          125000000
`define SDM_SAMP_FAST_HZ    128
`define SDM_SAMP_SLOW_HZ    32
`define SDM_UNLOCK_INSTR    4

`endif

// [rtl/sdm_pkg.sv]
// Purpose: Types shared by the dropout monitor files
// Assumes: Nothing beyond the configuration header
// Notes:   Operation codes are one-hot
package sdm_pkg;
    typedef enum logic [2:0] {
        SDM_OP_OFF  = 3'b001,
        SDM_OP_CONT = 3'b010,
        SDM_OP_SAMP = 3'b100
    } sdm_op_e;
    typedef logic [7:0] sdm_byte_t;
endpackage

// [rtl/sdm_sync.sv]
// Purpose: Three-stage synchroniser with agreement filter for analog comparator levels
// Assumes: Inputs are asynchronous levels
// Notes:   A bit changes only once stages two and three agree
`timescale 1ns/10ps
module sdm_sync #(
    parameter int W = 1
) (
    input  wire logic         mclk,   // System clock
    input  wire logic         rst_n,  // Synchronous reset, active low
    input  wire logic [W-1:0] din,    // Asynchronous levels
    output logic      [W-1:0] dout    // Filtered synchronous levels
);
    logic [W-1:0] s1_q;
    logic [W-1:0] s2_q;
    logic [W-1:0] s3_q;
    logic [W-1:0] out_q;
    wire  [W-1:0] agree = ~(s2_q ^ s3_q);

    // First stage feeds only the second
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            s1_q  <= '0;
            s2_q  <= '0;
            s3_q  <= '0;
            out_q <= '0;
        end else begin
            s1_q  <= din;
            s2_q  <= s1_q;
            s3_q  <= s2_q;
            out_q <= (agree & s3_q) | (~agree & out_q);
        end
    end
    assign dout = out_q;
endmodule

// [rtl/sdm_ctrl.sv]
// Purpose: Control logic of the supply dropout detector and its early warning monitor
// Assumes: APB slave with zero wait states; analog comparators sit outside
// Notes:   Byte registers sit in the low bits of aligned words
`timescale 1ns/10ps
`include "sdm_cfg.svh"
module sdm_ctrl #(
    parameter int SAMP_FAST_CYC = `SDM_CLK_HZ / `SDM_SAMP_FAST_HZ,
    parameter int SAMP_SLOW_CYC = `SDM_CLK_HZ / `SDM_SAMP_SLOW_HZ
) (
    input  wire logic              mclk,          // System clock, 125 MHz
    input  wire logic              rst_n,         // Synchronous reset, active low
    input  wire logic [11:0]       paddr,         // APB byte address
    input  wire logic              psel,          // APB select
    input  wire logic              penable,       // APB enable
    input  wire logic              pwrite,        // APB direction
    input  wire logic [31:0]       pwdata,        // APB write data
    output logic      [31:0]       prdata,        // APB read data
    output logic                   pready,        // APB ready
    output logic                   pslverr,       // APB error on unmapped address
    input  wire logic [7:0]        fuseByte,      // Fuse settings: rate, active, sleep
    input  wire logic [2:0]        fuseLevel,     // Fuse threshold level
    input  wire logic              unlockKey,     // Pulse: io unlock key written
    input  wire logic              instrRetire,   // Pulse: one instruction retired
    input  wire logic              deepSleep,     // Standby or power-down level
    input  wire logic              debugHalt,     // Processor halted in debug
    input  wire logic              dropBelow,     // Async: supply below threshold
    input  wire logic              warnBelow,     // Async: supply below warning level
    input  wire logic              detReady,      // Async: analog detector running
    output sdm_pkg::sdm_op_e       detMode,       // Current detector operation
    output logic                   detStrobe,     // Detector evaluation instant
    output logic [2:0]             detThreshold,  // Threshold level to analog
    output logic [1:0]             warnMargin,    // Warning margin to analog
    output logic                   warnPower,     // Warning comparator enabled
    output logic                   sysResetReq,   // Request system reset
    output logic                   execHold,      // Hold execution after wake
    output logic                   irqWarn        // Early warning interrupt request
);
    import sdm_pkg::*;

    // Refuse period counts that the 24-bit sample counter cannot hold
    generate
        if (SAMP_FAST_CYC < 2 || SAMP_SLOW_CYC < 2 || SAMP_FAST_CYC >= (1 << 24) ||
            SAMP_SLOW_CYC >= (1 << 24)) begin : g_bad
            $error("sample period counts out of range");
        end
    endgenerate

    // Decode a two-bit mode field to an operation
    function automatic sdm_op_e opOf(input logic [1:0] m);
        case (m)
            `SDM_MODE_CONT: opOf = SDM_OP_CONT;
            `SDM_MODE_SAMP: opOf = SDM_OP_SAMP;
            `SDM_MODE_WAKE: opOf = SDM_OP_CONT;
            default:        opOf = SDM_OP_OFF;
        endcase
    endfunction

    logic        sampRate_q;
    logic [1:0]  actMode_q;
    logic [1:0]  slpMode_q;
    logic [2:0]  level_q;
    logic [1:0]  margin_q;
    logic [1:0]  edgeSel_q;
    logic        irqEn_q;
    logic        flag_q;
    logic        flag_d;
    logic [2:0]  unlockCnt_q;
    logic [23:0] sampCnt_q;
    logic        sleep_q;
    logic        prevBelow_q;
    logic        warnState_q;
    logic        resetReq_q;
    logic        hold_q;
    logic        irq_q;
    logic [31:0] prdata_q;
    logic        pslverr_q;
    logic [2:0]  syncOut;

    sdm_sync #(.W(3)) u_sync (
        .mclk  (mclk),
        .rst_n (rst_n),
        .din   ({detReady, warnBelow, dropBelow}),
        .dout  (syncOut)
    );
    wire dropS  = syncOut[0];
    wire warnS  = syncOut[1];
    wire readyS = syncOut[2];

    // APB decode: index is the word address
    wire       setup    = psel & ~penable;
    wire       access   = psel & penable;
    wire [7:0] idx      = paddr[9:2];
    wire       aligned  = (paddr[1:0] == 2'b00) && (paddr[11:10] == 2'b00);
    wire       hitCtrlA = aligned && idx == `SDM_IDX_DETECTOR_CONTROL_A;
    wire       hitThr   = aligned && idx == `SDM_IDX_THRESH;
    wire       hitLvl   = aligned && idx == `SDM_IDX_WLEVEL;
    wire       hitIntc  = aligned && idx == `SDM_IDX_WINTC;
    wire       hitFlag  = aligned && idx == `SDM_IDX_WFLAG;
    wire       hitStat  = aligned && idx == `SDM_IDX_WSTATE;
    wire       mapped   = hitCtrlA | hitThr | hitLvl | hitIntc | hitFlag | hitStat;
    wire       wrEn     = access & pwrite & mapped;
    wire       wrCtrlA  = wrEn & hitCtrlA;
    wire       wrLvl    = wrEn & hitLvl;
    wire       wrIntc   = wrEn & hitIntc;
    wire       wrFlag   = wrEn & hitFlag;

    // Unlock window open for a bounded number of instructions
    wire unlocked = (unlockCnt_q != 3'd0);
    wire protWr   = wrCtrlA & unlocked;

    // Operation follows the sleep state; wake returns to the active field
    wire [1:0]   curField = deepSleep ? slpMode_q : actMode_q;
    wire sdm_op_e curOp   = opOf(curField);
    wire         detOn    = (curOp != SDM_OP_OFF);

    // Sample tick from the period counter; continuous mode evaluates every cycle
    wire [23:0] sampPeriod = sampRate_q ? 24'(SAMP_SLOW_CYC - 1) : 24'(SAMP_FAST_CYC - 1);
    wire        sampTick   = (sampCnt_q == 24'h00_0000);
    wire        evalTick   = (curOp == SDM_OP_CONT) | ((curOp == SDM_OP_SAMP) & sampTick);

    // Warning is live only with detector on, enable set and a margin chosen
    wire warnLive = detOn & irqEn_q & (margin_q != `SDM_MARGIN_OFF);
    wire fallX    = ~prevBelow_q & warnS;
    wire riseX    = prevBelow_q & ~warnS;
    wire edgeHit  = (edgeSel_q == `SDM_EDGE_FALL) ? fallX :
                    (edgeSel_q == `SDM_EDGE_RISE) ? riseX :
                    (edgeSel_q == `SDM_EDGE_BOTH) ? (fallX | riseX) : 1'b0;
    wire crossSet = warnLive & evalTick & edgeHit;
    wire ieRise   = wrIntc & pwdata[`SDM_IE_BIT] & ~irqEn_q;
    wire bothSet  = ieRise & detOn & (pwdata[`SDM_EDGE_LSB+:2] == `SDM_EDGE_BOTH);
    wire flagClr  = wrFlag & pwdata[`SDM_FLAG_BIT];

    // Set wins over a clear in the same cycle
    assign flag_d = crossSet | bothSet | (flag_q & ~flagClr);

    // Read data mux, reserved bits read zero
    wire [7:0] rdByte = hitCtrlA ? {3'b000, sampRate_q, actMode_q, slpMode_q} :
                        hitThr   ? {5'b00000, level_q} :
                        hitLvl   ? {6'b000000, margin_q} :
                        hitIntc  ? {5'b00000, edgeSel_q, irqEn_q} :
                        hitFlag  ? {7'b0000000, flag_q} :
                        hitStat  ? {7'b0000000, warnState_q} : 8'h00;

    // Fuse copies, loaded while reset is held so they are valid at release
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            actMode_q <= fuseByte[`SDM_ACT_LSB+:2];
            level_q   <= fuseLevel;
        end
    end

    // Protected fields: fuse at reset, software only through the unlock window
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            sampRate_q <= fuseByte[`SDM_SAMP_BIT];
            slpMode_q  <= fuseByte[`SDM_SLP_LSB+:2];
        end else if (protWr) begin
            sampRate_q <= pwdata[`SDM_SAMP_BIT];
            slpMode_q  <= pwdata[`SDM_SLP_LSB+:2];
        end
    end

    // Unlock counter: key loads it, retired instructions and the write consume it
    always_ff @(posedge mclk) begin
        if (!rst_n)
            unlockCnt_q <= 3'd0;
        else if (unlockKey)
            unlockCnt_q <= 3'(`SDM_UNLOCK_INSTR);
        else if (protWr)
            unlockCnt_q <= 3'd0;
        else if (unlocked && instrRetire)
            unlockCnt_q <= unlockCnt_q - 3'd1;
    end

    // Software warning registers
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            margin_q  <= `SDM_RST_WLEVEL;
            edgeSel_q <= `SDM_RST_WEDGE;
            irqEn_q   <= 1'b0;
        end else begin
            if (wrLvl)
                margin_q <= pwdata[1:0];
            if (wrIntc) begin
                edgeSel_q <= pwdata[`SDM_EDGE_LSB+:2];
                irqEn_q   <= pwdata[`SDM_IE_BIT];
            end
        end
    end

    // Flag and registered interrupt; debug halt withholds the request
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            flag_q <= 1'b0;
            irq_q  <= 1'b0;
        end else begin
            flag_q <= flag_d;
            irq_q  <= irqEn_q & flag_q & ~debugHalt;
        end
    end

    // Sample period counter; held at the period outside sampled operation, so sample instants stay evenly spaced
    always_ff @(posedge mclk) begin
        if (!rst_n)
            sampCnt_q <= 24'h00_0000;
        else if (sampTick || curOp != SDM_OP_SAMP)
            sampCnt_q <= sampPeriod;
        else
            sampCnt_q <= sampCnt_q - 24'h00_0001;
    end

    // Comparator evaluation; previous level only moves at evaluation instants
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            prevBelow_q <= 1'b0;
            warnState_q <= 1'b0;
            resetReq_q  <= 1'b0;
        end else if (!detOn) begin
            resetReq_q <= 1'b0;
        end else if (evalTick) begin
            prevBelow_q <= warnS;
            warnState_q <= warnLive & warnS;
            resetReq_q  <= dropS;
        end
    end

    // Execution hold after wake while the detector starts up
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            sleep_q <= 1'b0;
            hold_q  <= 1'b0;
        end else begin
            sleep_q <= deepSleep;
            if (sleep_q && !deepSleep && actMode_q == `SDM_MODE_WAKE)
                hold_q <= 1'b1;
            else if (readyS)
                hold_q <= 1'b0;
        end
    end

    // APB read data and error captured in setup so they stand through access
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            prdata_q  <= 32'h0000_0000;
            pslverr_q <= 1'b0;
        end else if (setup) begin
            prdata_q  <= pwrite ? 32'h0000_0000 : {24'h00_0000, rdByte};
            pslverr_q <= ~mapped;
        end
    end

    // Outputs
    assign prdata       = prdata_q;
    assign pslverr      = pslverr_q & access;
    assign pready       = 1'b1;
    assign detMode      = curOp;
    assign detStrobe    = evalTick;
    assign detThreshold = level_q;
    assign warnMargin   = margin_q;
    assign warnPower    = warnLive;
    assign sysResetReq  = resetReq_q;
    assign execHold     = hold_q;
    assign irqWarn      = irq_q;

    // Checks
    a_flag_set_wins: assert property (@(posedge mclk) disable iff (!rst_n)
        (crossSet || bothSet) |=> flag_q) else $error("flag set lost");
    a_flag_clear: assert property (@(posedge mclk) disable iff (!rst_n)
        flag_q && flagClr && !crossSet && !bothSet |=> !flag_q ##1 !irqWarn)
        else $error("flag clear failed");
    a_irq_debug: assert property (@(posedge mclk) disable iff (!rst_n)
        debugHalt |=> !irqWarn) else $error("interrupt during debug halt");
    a_irq_pair: assert property (@(posedge mclk) disable iff (!rst_n)
        irqEn_q && flag_q && !debugHalt |=> irqWarn) else $error("interrupt missing");
    a_locked_ctrl: assert property (@(posedge mclk) disable iff (!rst_n)
        wrCtrlA && !unlocked |=> $stable(slpMode_q) && $stable(sampRate_q))
        else $error("protected bits changed while locked");
    a_active_fixed: assert property (@(posedge mclk) disable iff (!rst_n)
        ##1 $stable(actMode_q) && $stable(level_q)) else $error("fuse field changed");
    a_fuse_load: assert property (@(posedge mclk)
        !rst_n |=> actMode_q == $past(fuseByte[3:2]) && level_q == $past(fuseLevel))
        else $error("fuse values not loaded");
    a_off_silent: assert property (@(posedge mclk) disable iff (!rst_n)
        !detOn && !flag_q |=> !flag_q) else $error("flag rose with detector off");
    a_both_enable: assert property (@(posedge mclk) disable iff (!rst_n)
        ieRise && detOn && pwdata[2:1] == `SDM_EDGE_BOTH |=>
        flag_q ##1 (irqWarn || $past(debugHalt)))
        else $error("both-edge enable did not set flag");
    a_sleep_mode: assert property (@(posedge mclk) disable iff (!rst_n)
        deepSleep && slpMode_q == `SDM_MODE_DIS |-> detMode == SDM_OP_OFF)
        else $error("sleep field not followed");
    // A mode change right after a sample instant may legally strobe again
    a_samp_eval: assert property (@(posedge mclk) disable iff (!rst_n)
        curOp == SDM_OP_SAMP && detStrobe |=> !detStrobe || curOp != SDM_OP_SAMP)
        else $error("sampled too often");

    // Sleep, wake and reset request checks
    a_sleep_cont: assert property (@(posedge mclk) disable iff (!rst_n)
        deepSleep && slpMode_q == `SDM_MODE_CONT |-> detMode == SDM_OP_CONT)
        else $error("sleep continuous not followed");
    a_wake_return: assert property (@(posedge mclk) disable iff (!rst_n)
        !deepSleep && actMode_q[0] |-> detMode == SDM_OP_CONT)
        else $error("active field not followed after wake");
    a_wake_hold: assert property (@(posedge mclk) disable iff (!rst_n)
        sleep_q && !deepSleep && actMode_q == `SDM_MODE_WAKE |=> execHold)
        else $error("execution hold missing after wake");
    a_hold_release: assert property (@(posedge mclk) disable iff (!rst_n)
        hold_q && readyS && !(sleep_q && !deepSleep) |=> !execHold)
        else $error("execution hold not released");
    a_reset_off: assert property (@(posedge mclk) disable iff (!rst_n)
        !detOn |=> !sysResetReq) else $error("reset request with detector off");
    a_reset_follow: assert property (@(posedge mclk) disable iff (!rst_n)
        detOn && evalTick && dropS |=> sysResetReq)
        else $error("reset request missing");

    // Unlock window and strobe checks
    a_unlock_expire: assert property (@(posedge mclk) disable iff (!rst_n)
        unlockCnt_q == 3'd1 && instrRetire && !unlockKey |=> !unlocked)
        else $error("unlock window outlived its instructions");
    a_prot_write: assert property (@(posedge mclk) disable iff (!rst_n)
        protWr |=> slpMode_q == $past(pwdata[`SDM_SLP_LSB+:2]) &&
        sampRate_q == $past(pwdata[`SDM_SAMP_BIT])) else $error("unlocked write not taken");
    a_off_strobe: assert property (@(posedge mclk) disable iff (!rst_n)
        !detOn |-> !detStrobe && !warnPower)
        else $error("strobe or warning power with detector off");
    a_samp_reload: assert property (@(posedge mclk) disable iff (!rst_n)
        curOp == SDM_OP_SAMP && sampTick |=> sampCnt_q == $past(sampPeriod))
        else $error("sample period not reloaded");

    // Flag, interrupt and warning power checks
    a_flag_hold: assert property (@(posedge mclk) disable iff (!rst_n)
        !crossSet && !bothSet && !flagClr |=> flag_q == $past(flag_q))
        else $error("flag moved without cause");
    a_irq_clear: assert property (@(posedge mclk) disable iff (!rst_n)
        !flag_q |=> !irqWarn) else $error("interrupt without flag");
    a_margin_off: assert property (@(posedge mclk) disable iff (!rst_n)
        margin_q == `SDM_MARGIN_OFF |-> !warnPower) else $error("warning powered at margin off");

    // Main scenarios
    c_cross: cover property (@(posedge mclk) disable iff (!rst_n) crossSet);
    c_unlock_wr: cover property (@(posedge mclk) disable iff (!rst_n) protWr);
    c_wake_hold: cover property (@(posedge mclk) disable iff (!rst_n) $rose(hold_q));
    c_reset_req: cover property (@(posedge mclk) disable iff (!rst_n) $rose(sysResetReq));
    c_both_set: cover property (@(posedge mclk) disable iff (!rst_n) bothSet);
endmodule

// [sim/tb_top.sv]
// Purpose: Self-checking bench for the dropout monitor control block over APB
// Assumes: Zero-wait APB slave; sample periods shortened to 8 and 16 cycles
// Notes:   Analog levels are driven directly; the synchroniser adds a few cycles
`timescale 1ns/10ps
`include "sdm_cfg.svh"
module tb_top;
    import sdm_pkg::*;
    localparam logic [7:0] FUSE_B = 8'h16; // Rate slow, active continuous, sleep sampled
    localparam logic [2:0] FUSE_L = 3'h5;
    logic        mclk;
    logic        rst_n;
    logic [11:0] paddr;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        unlockKey;
    logic        instrRetire;
    logic        deepSleep;
    logic        debugHalt;
    logic        dropBelow;
    logic        warnBelow;
    logic [7:0]  fuseB;
    logic        detReady;
    logic        execHold;
    sdm_op_e     detMode;
    logic        detStrobe;
    logic [2:0]  detThreshold;
    logic [1:0]  warnMargin;
    logic        warnPower;
    logic        sysResetReq;
    logic        irqWarn;
    int          error_cnt = 0;
    int          checked = 0;
    int          n;
    logic [31:0] rdat;
    logic        rerr;

    sdm_ctrl #(.SAMP_FAST_CYC(8), .SAMP_SLOW_CYC(16)) u_sdm_ctrl (
        .mclk(mclk), .rst_n(rst_n), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .fuseByte(fuseB), .fuseLevel(FUSE_L), .unlockKey(unlockKey),
        .instrRetire(instrRetire), .deepSleep(deepSleep), .debugHalt(debugHalt),
        .dropBelow(dropBelow), .warnBelow(warnBelow), .detReady(detReady), .detMode(detMode),
        .detStrobe(detStrobe), .detThreshold(detThreshold), .warnMargin(warnMargin),
        .warnPower(warnPower), .sysResetReq(sysResetReq), .execHold(execHold),
        .irqWarn(irqWarn));

    // Clock, 8 ns period
    initial mclk = 1'b0;
    always #4 mclk = ~mclk;

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic final_report;
        $display("Comparisons %0d, mismatches %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    task automatic tick(input int c);
        repeat (c) @(posedge mclk);
    endtask

    // One APB transfer; psel drops for a cycle between calls so no signal is set twice
    task automatic apb(input logic w, input logic [7:0] idx, input logic [7:0] d);
        @(posedge mclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= {2'b00, idx, 2'b00};
        pwdata  <= {24'h0000_00, d};
        @(posedge mclk);
        penable <= 1'b1;
        do begin
            @(posedge mclk);
        end while (pready !== 1'b1); // Only the watchdog ends a stuck wait
        rdat = prdata;
        rerr = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] idx, input logic [7:0] exp);
        apb(1'b0, idx, 8'h00);
        chk(rdat, {24'h0000_00, exp});
    endtask

    // Unlock key, then nret retired instructions, then the control write
    task automatic prot(input int nret, input logic [7:0] d);
        @(posedge mclk);
        unlockKey <= 1'b1;
        @(posedge mclk);
        unlockKey <= 1'b0;
        if (nret > 0) begin
            instrRetire <= 1'b1;
            repeat (nret) @(posedge mclk);
            instrRetire <= 1'b0;
        end
        apb(1'b1, `SDM_IDX_DETECTOR_CONTROL_A, d);
    endtask

    // Strobes seen over 32 cycles
    task automatic cnt(output int c);
        c = 0;
        repeat (32) begin
            @(negedge mclk);
            if (detStrobe === 1'b1) c++;
        end
    endtask

    // Watchdog: the whole sequence needs well under a thousand cycles
    initial begin
        tick(20000);
        error_cnt++;
        final_report;
    end

    initial begin
        {rst_n, psel, penable, pwrite, unlockKey, instrRetire} = '0;
        {deepSleep, debugHalt, dropBelow, warnBelow} = '0;
        fuseB = FUSE_B;
        detReady = 1'b1;
        paddr = '0;
        pwdata = '0;
        tick(2); // Two reset edges; the synchroniser clears on the first
        rst_n <= 1'b1;
        rd(`SDM_IDX_DETECTOR_CONTROL_A, FUSE_B);
        rd(`SDM_IDX_THRESH, {5'h00, FUSE_L});
        chk(detThreshold, FUSE_L);
        chk(detMode, SDM_OP_CONT);
        apb(1'b1, `SDM_IDX_DETECTOR_CONTROL_A, 8'h00);
        rd(`SDM_IDX_DETECTOR_CONTROL_A, FUSE_B);
        apb(1'b1, `SDM_IDX_THRESH, 8'h00);
        rd(`SDM_IDX_THRESH, {5'h00, FUSE_L});
        prot(4, 8'h01);
        rd(`SDM_IDX_DETECTOR_CONTROL_A, FUSE_B);
        prot(3, 8'h0D); // Active bits try 3, must stay fuse value
        rd(`SDM_IDX_DETECTOR_CONTROL_A, 8'h05);
        apb(1'b0, 8'h04, 8'h00);
        chk(rerr, 1'b1);
        // Sleep entry and exit, detector off while asleep once the sleep field is written disabled
        deepSleep <= 1'b1;
        tick(1);
        chk(detMode, SDM_OP_CONT);
        prot(0, 8'h00);
        rd(`SDM_IDX_DETECTOR_CONTROL_A, 8'h04);
        chk(detMode, SDM_OP_OFF);
        apb(1'b1, `SDM_IDX_WLEVEL, 8'h01);
        apb(1'b1, `SDM_IDX_WINTC, 8'h05);
        warnBelow <= 1'b1;
        tick(10);
        rd(`SDM_IDX_WFLAG, 8'h00);
        chk(warnPower, 1'b0);
        warnBelow <= 1'b0;
        tick(10);
        deepSleep <= 1'b0;
        tick(1);
        chk(detMode, SDM_OP_CONT);
        apb(1'b1, `SDM_IDX_WFLAG, 8'h01);
        // Enabling with both-edge select sets the flag at once
        apb(1'b1, `SDM_IDX_WINTC, 8'h00);
        apb(1'b1, `SDM_IDX_WINTC, 8'h05);
        tick(2);
        rd(`SDM_IDX_WFLAG, 8'h01);
        chk(irqWarn, 1'b1);
        debugHalt <= 1'b1;
        tick(2);
        chk(irqWarn, 1'b0);
        debugHalt <= 1'b0;
        apb(1'b1, `SDM_IDX_WFLAG, 8'h01);
        tick(2);
        rd(`SDM_IDX_WFLAG, 8'h00);
        chk(irqWarn, 1'b0);
        // Falling then rising select: enabling sets nothing, the crossing does
        for (int e = 0; e < 2; e++) begin
            apb(1'b1, `SDM_IDX_WINTC, 8'h00);
            apb(1'b1, `SDM_IDX_WINTC, {5'h00, e[1:0], 1'b1});
            tick(2);
            rd(`SDM_IDX_WFLAG, 8'h00);
            warnBelow <= (e == 0);
            tick(10);
            rd(`SDM_IDX_WFLAG, 8'h01);
            rd(`SDM_IDX_WSTATE, {7'h00, e == 0});
            apb(1'b1, `SDM_IDX_WFLAG, 8'h01);
        end
        apb(1'b1, `SDM_IDX_WLEVEL, 8'h00);
        tick(1); // The write lands at the edge the task returns on
        chk(warnPower, 1'b0);
        apb(1'b1, `SDM_IDX_WLEVEL, 8'h03);
        rd(`SDM_IDX_WLEVEL, 8'h03);
        chk(warnMargin, 2'h3);
        chk(warnPower, 1'b1);
        // Sampled operation in sleep, fast then slow rate
        prot(0, 8'h02);
        deepSleep <= 1'b1;
        tick(1);
        chk(detMode, SDM_OP_SAMP);
        cnt(n);
        chk(n, 4);
        prot(0, 8'h12);
        cnt(n);
        chk(n, 2);
        tick(1); // Back on a rising edge before driving
        deepSleep <= 1'b0;
        // Supply below threshold asks for a system reset
        dropBelow <= 1'b1;
        tick(10);
        chk(sysResetReq, 1'b1);
        dropBelow <= 1'b0;
        tick(10);
        chk(sysResetReq, 1'b0);
        // Second reset with the wake-hold code; detector not yet running
        fuseB    <= 8'h0D;
        detReady <= 1'b0;
        rst_n    <= 1'b0;
        tick(2);
        rst_n    <= 1'b1;
        tick(1);
        rd(`SDM_IDX_DETECTOR_CONTROL_A, 8'h0D);
        chk(detMode, SDM_OP_CONT);
        deepSleep <= 1'b1;
        tick(2);
        deepSleep <= 1'b0;
        tick(2);
        chk(execHold, 1'b1);
        detReady <= 1'b1;
        tick(8);
        chk(execHold, 1'b0);
        final_report;
    end
endmodule
